// ===== logic/dma_controller_map.svh
`ifndef DMA_CONTROLLER_MAP_SVH
`define DMA_CONTROLLER_MAP_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DMA_CONTROLLER_CH_SEL_HI 6
`define DMA_CONTROLLER_CH_SEL_LO 5
`define DMA_CONTROLLER_REG_SEL_HI 4
`define DMA_CONTROLLER_REG_SEL_LO 0
`define DMA_CONTROLLER_OFS_SAR 5'h00
`define DMA_CONTROLLER_OFS_DAR 5'h04
`define DMA_CONTROLLER_OFS_OFR 5'h08
`define DMA_CONTROLLER_OFS_TCR 5'h0c
`define DMA_CONTROLLER_OFS_CTL 5'h10
`define DMA_CONTROLLER_GLOBAL_BIT 7
`define DMA_CONTROLLER_OFS_IST 8'h80
`define DMA_CONTROLLER_OFS_IMSK 8'h84
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define DMA_CONTROLLER_CTL_W 9
`define DMA_CONTROLLER_CTL_RUN 0
// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define DMA_CONTROLLER_SZ_BYTE 2'h0
`define DMA_CONTROLLER_SZ_WORD 2'h1
`define DMA_CONTROLLER_AM_FIXED 2'h0
`define DMA_CONTROLLER_AM_OFFSET 2'h1
`define DMA_CONTROLLER_AM_INC 2'h2
`define DMA_CONTROLLER_AM_DEC 2'h3
`define DMA_CONTROLLER_BYTES_1 32'h0000_0001
`define DMA_CONTROLLER_BYTES_2 32'h0000_0002
`define DMA_CONTROLLER_BYTES_4 32'h0000_0004
`define DMA_CONTROLLER_FREE_RUN 32'h0000_0000
`define DMA_CONTROLLER_RST32 32'h0000_0000
`endif

// ===== logic/dma_controller_pkg.sv
package dma_controller_pkg;
  // ----------------------------------------------------------------
  // Channel control word, bit 0 is the run bit
  // ----------------------------------------------------------------
  typedef struct packed {
    logic dir;            // Single address: 1 = address is dest
    logic single;         // Single address mode
    logic [1:0] dst_mode; // Destination update mode
    logic [1:0] src_mode; // Source update mode
    logic [1:0] size;     // Access size byte/word/long
    logic run;            // Channel running
  } dma_controller_ctrl_t;
  // ----------------------------------------------------------------
  // Address and count set of one channel
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] src; // Source address
    logic [31:0] dst; // Destination address
    logic [31:0] ofs; // Offset step
    logic [31:0] cnt; // Remaining bytes
  } dma_controller_regs_t;
  // ----------------------------------------------------------------
  // Per-channel write selects
  // ----------------------------------------------------------------
  typedef struct packed {
    logic src;
    logic dst;
    logic ofs;
    logic cnt;
  } dma_controller_wsel_t;
  // ----------------------------------------------------------------
  // Channel run state
  // ----------------------------------------------------------------
  typedef enum logic {DMA_CONTROLLER_IDLE, DMA_CONTROLLER_RUN} dma_controller_state_t;
endpackage

// ===== logic/dma_controller_irq.sv
`timescale 1ns/1ps
`include "dma_controller_map.svh"
module dma_controller_irq #(
  parameter int N = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [N-1:0] event_in,
  input wire logic status_rd,
  input wire logic mask_we,
  input wire logic [N-1:0] mask_wdata,
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);
  // ----------------------------------------------------------------
  // Sticky status, mask and interrupt line
  // ----------------------------------------------------------------
  logic [N-1:0] status_reg; // Sticky event bits
  logic [N-1:0] status_next;
  logic [N-1:0] mask_reg; // Interrupt enables
  logic [N-1:0] mask_next;
  logic irq_reg; // Level interrupt
  logic irq_next;

  // Next values, an event in the read cycle stays set
  always_comb begin
    status_next = status_rd ? event_in : (status_reg | event_in);
    mask_next = mask_we ? mask_wdata : mask_reg;
    irq_next = |(status_next & mask_next);
  end

  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg <= '0;
      mask_reg <= '0;
      irq_reg <= 1'b0;
    end else if (ce) begin
      status_reg <= status_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
    end
  end

  assign status = status_reg;
  assign mask = mask_reg;
  assign irq = irq_reg;
endmodule // dma_controller_irq

// ===== logic/dma_controller_chan.sv
`timescale 1ns/1ps
`include "dma_controller_map.svh"
module dma_controller_chan (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input dma_controller_pkg::dma_controller_wsel_t wsel,
  input wire logic [31:0] wdata,
  input dma_controller_pkg::dma_controller_ctrl_t ctrl,
  input wire logic step,
  output dma_controller_pkg::dma_controller_regs_t regs,
  output logic done,
  output logic escape
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dma_controller_pkg::dma_controller_regs_t regs_reg; // Address and count set
  dma_controller_pkg::dma_controller_regs_t regs_next;
  logic done_reg; // Count reached zero
  logic done_next;
  logic esc_reg; // Too few bytes left
  logic esc_next;
  logic [31:0] bytes; // Bytes per transfer
  logic [31:0] cnt_left; // Count after this transfer

  // Next address for one update mode, wraps at 32 bits [RULE_16]
  function automatic logic [31:0] upd(input logic [31:0] a,
                                      input logic [1:0] mode,
                                      input logic [31:0] ofs,
                                      input logic [31:0] b);
    logic [31:0] r;
    r = a;
    unique case (mode)
      `DMA_CONTROLLER_AM_FIXED: r = a;
      `DMA_CONTROLLER_AM_OFFSET: r = a + ofs;
      `DMA_CONTROLLER_AM_INC: r = a + b;
      `DMA_CONTROLLER_AM_DEC: r = a - b;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  always_comb begin
    regs_next = regs_reg;
    done_next = 1'b0;
    esc_next = 1'b0;
    // Step size per access size [RULE_13]
    if (ctrl.size == `DMA_CONTROLLER_SZ_BYTE) begin
      bytes = `DMA_CONTROLLER_BYTES_1;
    end else if (ctrl.size == `DMA_CONTROLLER_SZ_WORD) begin
      bytes = `DMA_CONTROLLER_BYTES_2;
    end else begin
      bytes = `DMA_CONTROLLER_BYTES_4;
    end
    cnt_left = regs_reg.cnt - bytes;
    // No step in the end cycle: run state drops one edge later
    if (step && ctrl.run && !done_reg && !esc_reg) begin
      // Fewer bytes left than one access: end without moving [RULE_15]
      if (regs_reg.cnt != `DMA_CONTROLLER_FREE_RUN && regs_reg.cnt < bytes) begin
        esc_next = 1'b1;
      end else begin
        // Source unused when address names the destination [RULE_03]
        if (!(ctrl.single && ctrl.dir)) begin
          // Same offset on both sides [RULE_09]
          regs_next.src = upd(regs_reg.src, ctrl.src_mode,
                              regs_reg.ofs, bytes); // [RULE_02]
        end
        // Destination unused when address names the source [RULE_05]
        if (!(ctrl.single && !ctrl.dir)) begin
          regs_next.dst = upd(regs_reg.dst, ctrl.dst_mode,
                              regs_reg.ofs, bytes); // [RULE_04]
        end
        // Zero count holds: free running [RULE_11]
        if (regs_reg.cnt != `DMA_CONTROLLER_FREE_RUN) begin
          regs_next.cnt = cnt_left; // [RULE_10]
          done_next = (cnt_left == `DMA_CONTROLLER_FREE_RUN); // [RULE_14]
        end
      end
    end
    // Software writes take the register
    if (wsel.src) begin
      regs_next.src = wdata; // [RULE_02]
    end
    if (wsel.dst) begin
      regs_next.dst = wdata; // [RULE_04]
    end
    if (wsel.ofs) begin
      regs_next.ofs = wdata; // [RULE_08]
    end
    if (wsel.cnt) begin
      regs_next.cnt = wdata; // [RULE_12]
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regs_reg <= {4{`DMA_CONTROLLER_RST32}}; // [RULE_17]
      done_reg <= 1'b0;
      esc_reg <= 1'b0;
    end else if (ce) begin
      regs_reg <= regs_next;
      done_reg <= done_next;
      esc_reg <= esc_next;
    end
  end

  assign regs = regs_reg;
  assign done = done_reg;
  assign escape = esc_reg;
endmodule // dma_controller_chan

// ===== logic/dma_controller_top.sv
// How it works
// [RULE_01] Four channels, each with own registers
// [RULE_02] Source address read/write, advances per transfer
// [RULE_03] Single mode, direction one: source ignored
// [RULE_04] Destination address read/write, advances per transfer
// [RULE_05] Single mode, direction zero: destination ignored
// [RULE_06] Addresses and count readable at any time
// [RULE_07] Software reads longwords, no writes while busy; the code takes register writes while the channel runs
// [RULE_08] Offset register read/write, used as step
// [RULE_09] One offset serves both source and destination
// [RULE_10] Count is total bytes to move
// [RULE_11] Zero count means free running, held
// [RULE_12] All-ones count is largest total size
// [RULE_13] Count drops by one, two or four
// [RULE_14] Count reaching zero raises transfer end
// [RULE_15] Too few bytes left raises escape end
// [RULE_16] Address updates wrap at thirty-two bits
// [RULE_17] Reset clears addresses, offset and count
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "dma_controller_map.svh"
module dma_controller_top #(
  parameter int NCH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  input wire logic [NCH-1:0] xfer_step,
  output dma_controller_pkg::dma_controller_regs_t chan_regs [NCH],
  output logic [NCH-1:0] chan_busy,
  output logic [NCH-1:0] xfer_done,
  output logic [NCH-1:0] xfer_escape,
  output logic irq
);
  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [1:0] ch_sel; // Channel index
  logic [4:0] reg_sel; // Register within channel
  logic is_global; // Global register page
  logic ch_hit; // Channel page, channel exists

  // Split the address into page, channel and register
  always_comb begin
    ch_sel = reg_addr[`DMA_CONTROLLER_CH_SEL_HI:`DMA_CONTROLLER_CH_SEL_LO];
    reg_sel = reg_addr[`DMA_CONTROLLER_REG_SEL_HI:`DMA_CONTROLLER_REG_SEL_LO];
    is_global = reg_addr[`DMA_CONTROLLER_GLOBAL_BIT];
    ch_hit = !is_global && (int'(ch_sel) < NCH);
  end

  // ----------------------------------------------------------------
  // Channel control registers and run state
  // ----------------------------------------------------------------
  dma_controller_pkg::dma_controller_ctrl_t ctl_reg [NCH]; // Control fields
  dma_controller_pkg::dma_controller_ctrl_t ctl_next [NCH];
  dma_controller_pkg::dma_controller_state_t st_reg [NCH]; // Run state
  dma_controller_pkg::dma_controller_state_t st_next [NCH];
  logic [NCH-1:0] busy_reg; // Busy mirror for the port
  logic [NCH-1:0] busy_next;
  dma_controller_pkg::dma_controller_ctrl_t ctl_eff [NCH]; // Control with live run bit
  dma_controller_pkg::dma_controller_wsel_t wsel [NCH]; // Write selects per channel
  dma_controller_pkg::dma_controller_regs_t regs [NCH]; // Channel register sets
  logic [NCH-1:0] done; // Transfer end pulses
  logic [NCH-1:0] esc; // Escape end pulses

  // Control next values and write selects
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      ctl_next[i] = ctl_reg[i];
      st_next[i] = st_reg[i];
      wsel[i] = '0;
      // A finished channel stops
      if (done[i] || esc[i]) begin
        st_next[i] = dma_controller_pkg::DMA_CONTROLLER_IDLE;
      end
      if (reg_we && ch_hit && int'(ch_sel) == i) begin
        wsel[i].src = (reg_sel == `DMA_CONTROLLER_OFS_SAR);
        wsel[i].dst = (reg_sel == `DMA_CONTROLLER_OFS_DAR);
        wsel[i].ofs = (reg_sel == `DMA_CONTROLLER_OFS_OFR);
        wsel[i].cnt = (reg_sel == `DMA_CONTROLLER_OFS_TCR);
        if (reg_sel == `DMA_CONTROLLER_OFS_CTL) begin
          ctl_next[i] = reg_wdata[`DMA_CONTROLLER_CTL_W-1:0];
          // Run bit starts or stops the channel
          if (reg_wdata[`DMA_CONTROLLER_CTL_RUN]) begin
            st_next[i] = dma_controller_pkg::DMA_CONTROLLER_RUN;
          end else begin
            st_next[i] = dma_controller_pkg::DMA_CONTROLLER_IDLE;
          end
        end
      end
      busy_next[i] = (st_next[i] == dma_controller_pkg::DMA_CONTROLLER_RUN);
      // Live run bit comes from the state
      ctl_eff[i] = ctl_reg[i];
      ctl_eff[i].run = (st_reg[i] == dma_controller_pkg::DMA_CONTROLLER_RUN);
    end
  end

  // Control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        ctl_reg[i] <= '0;
        st_reg[i] <= dma_controller_pkg::DMA_CONTROLLER_IDLE;
      end
      busy_reg <= '0;
    end else if (ce) begin
      for (int i = 0; i < NCH; i++) begin
        ctl_reg[i] <= ctl_next[i];
        st_reg[i] <= st_next[i];
      end
      busy_reg <= busy_next;
    end
  end

  // ----------------------------------------------------------------
  // Channel address and count units
  // ----------------------------------------------------------------
  // One unit per channel [RULE_01]
  for (genvar g = 0; g < NCH; g++) begin : g_chan
    dma_controller_chan u_chan (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .wsel(wsel[g]),
      .wdata(reg_wdata),
      .ctrl(ctl_eff[g]),
      .step(xfer_step[g]),
      .regs(regs[g]),
      .done(done[g]),
      .escape(esc[g])
    );
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [2*NCH-1:0] ist; // Sticky status, escape above end
  logic [2*NCH-1:0] imsk; // Mask
  logic ist_rd; // Status read clears
  logic imsk_we; // Mask write
  logic irq_w; // Interrupt from the status unit

  // Global register strobes
  always_comb begin
    ist_rd = reg_re && (reg_addr == `DMA_CONTROLLER_OFS_IST);
    imsk_we = reg_we && (reg_addr == `DMA_CONTROLLER_OFS_IMSK);
  end

  // Both end kinds reach the CPU [RULE_14] [RULE_15]
  dma_controller_irq #(
    .N(2*NCH)
  ) u_irq (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .event_in({esc, done}),
    .status_rd(ist_rd),
    .mask_we(imsk_we),
    .mask_wdata(reg_wdata[2*NCH-1:0]),
    .status(ist),
    .mask(imsk),
    .irq(irq_w)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rdata_reg; // Read data, one cycle after strobe
  logic [31:0] rdata_next;

  // Read mux, open while the channel runs [RULE_06]
  always_comb begin
    rdata_next = `DMA_CONTROLLER_RST32;
    if (reg_re) begin
      if (ch_hit) begin
        unique case (reg_sel)
          `DMA_CONTROLLER_OFS_SAR: rdata_next = regs[ch_sel].src;
          `DMA_CONTROLLER_OFS_DAR: rdata_next = regs[ch_sel].dst;
          `DMA_CONTROLLER_OFS_OFR: rdata_next = regs[ch_sel].ofs;
          `DMA_CONTROLLER_OFS_TCR: rdata_next = regs[ch_sel].cnt;
          `DMA_CONTROLLER_OFS_CTL: begin
            rdata_next[`DMA_CONTROLLER_CTL_W-1:0] = ctl_eff[ch_sel];
          end
          default: rdata_next = `DMA_CONTROLLER_RST32;
        endcase
      end else if (reg_addr == `DMA_CONTROLLER_OFS_IST) begin
        rdata_next[2*NCH-1:0] = ist;
      end else if (reg_addr == `DMA_CONTROLLER_OFS_IMSK) begin
        rdata_next[2*NCH-1:0] = imsk;
      end
    end
  end

  // Read data register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= `DMA_CONTROLLER_RST32;
    end else if (ce) begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each from a flip-flop
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_reg;
  assign chan_busy = busy_reg;
  assign xfer_done = done;
  assign xfer_escape = esc;
  assign irq = irq_w;
  assign chan_regs = regs;
endmodule // dma_controller_top

// ===== tb/dma_controller_top_properties.sv
`timescale 1ns/1ps
// ----
// Port checker of the channel register block
// ----
module dma_controller_top_properties #(
  parameter int NCH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [31:0] reg_rdata,
  input wire logic [NCH-1:0] xfer_step,
  input dma_controller_pkg::dma_controller_regs_t chan_regs [NCH],
  input wire logic [NCH-1:0] chan_busy,
  input wire logic [NCH-1:0] xfer_done,
  input wire logic [NCH-1:0] xfer_escape,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Read data is zero outside its one cycle
  property p_rd_zero;
    (ce && !reg_re) |=> reg_rdata == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("stale read data");
  // Live count readable at any time
  property p_rd_cnt;
    (ce && reg_re && reg_addr == 8'h2c) |=> reg_rdata == $past(chan_regs[1].cnt);
  endproperty
  a_rd_cnt: assert property (p_rd_cnt) else $error("count read wrong");
  // Transfer end only at a zero count
  property p_done_cnt;
    xfer_done[1] |-> chan_regs[1].cnt == 32'h0;
  endproperty
  a_done_cnt: assert property (p_done_cnt) else $error("end, count left");
  // Channel stops on the edge after the end pulse
  property p_done_busy;
    (ce && xfer_done[1] && !reg_we) |=> !chan_busy[1];
  endproperty
  a_done_busy: assert property (p_done_busy) else $error("busy after end");
  // No further transfer once the count has run out
  property p_done_hold;
    (ce && xfer_done[1] && !reg_we) |=> $stable(chan_regs[1]);
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("moved after end");
  // Escape only when fewer bytes than one access remain
  property p_escape;
    xfer_escape[2] |-> chan_regs[2].cnt != 32'h0 && chan_regs[2].cnt < 32'h4;
  endproperty
  a_escape: assert property (p_escape) else $error("bad escape");
  // Free running holds the count and never ends
  property p_free;
    (ce && chan_busy[0] && xfer_step[0] && chan_regs[0].cnt == 32'h0 && !reg_we)
      |=> chan_regs[0].cnt == 32'h0 && !xfer_done[0];
  endproperty
  a_free: assert property (p_free) else $error("free run moved");
  // Count drops by an access size or holds
  property p_cnt_drop;
    (ce && chan_busy[3] && xfer_step[3] && !reg_we) |=>
      ($past(chan_regs[3].cnt) - chan_regs[3].cnt) inside
      {32'h0, 32'h1, 32'h2, 32'h4};
  endproperty
  a_cnt_drop: assert property (p_cnt_drop) else $error("bad count step");
  // Step on an idle channel changes nothing
  property p_idle_step;
    (ce && xfer_step[1] && !chan_busy[1] && !reg_we) |=> $stable(chan_regs[1]);
  endproperty
  a_idle_step: assert property (p_idle_step) else $error("idle moved");
  // Interrupt rises only after an event or a write
  property p_irq;
    $rose(irq) |-> $past(|(xfer_done | xfer_escape)) || $past(reg_we) ||
      $past(reg_we, 2);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
endmodule // dma_controller_top_properties

bind dma_controller_top dma_controller_top_properties #(.NCH(NCH)) dma_controller_top_properties_i (
  .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_we(reg_we),
  .reg_re(reg_re), .reg_rdata(reg_rdata), .xfer_step(xfer_step),
  .chan_regs(chan_regs), .chan_busy(chan_busy), .xfer_done(xfer_done),
  .xfer_escape(xfer_escape), .irq(irq));

// ===== tb/dma_controller_seq_model.sv
`timescale 1ns/1ps
// ----
// Transfer sequencer: asks steps on wanted channels
// ----
module dma_controller_seq_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] want,
  input wire logic slow,
  output logic [3:0] xfer_step
);
  logic tog_reg; // Pacing toggle for slow mode
  // Prompt: every cycle; slow: every other cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tog_reg <= 1'b0;
      xfer_step <= 4'h0;
    end else begin
      tog_reg <= ~tog_reg;
      xfer_step <= want & {4{~slow | tog_reg}};
    end
  end
endmodule // dma_controller_seq_model

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`include "dma_controller_map.svh"
module tb_top;
  logic clk, rst, ce, reg_we, reg_re, slow, irq;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0] want, xfer_step, chan_busy, xfer_done, xfer_escape;
  dma_controller_pkg::dma_controller_regs_t chan_regs [4];
  int failures = 0, n_tests = 0, nstep [4];
  dma_controller_top #(.NCH(4)) dma_controller_top_i (.clk(clk), .rst(rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .xfer_step(xfer_step),
    .chan_regs(chan_regs), .chan_busy(chan_busy), .xfer_done(xfer_done),
    .xfer_escape(xfer_escape), .irq(irq));
  dma_controller_seq_model dma_controller_seq_model_i (.clk(clk), .rst(rst), .want(want),
    .slow(slow), .xfer_step(xfer_step));
  always #5 clk = ~clk;
  // Count steps the channels accept
  always @(posedge clk)
    for (int i = 0; i < 4; i++)
      if (!rst && ce && xfer_step[i] && chan_busy[i]) nstep[i]++;
  // ----
  // Bus tasks
  // ----
  task automatic close_out;
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One write; address registers only while idle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  // Longword read, data in the next cycle only
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, {31'h0, v});
  endtask
  // Run a channel until it stops, bounded
  task automatic go(input int ch);
    int k;
    want[ch] <= 1'b1;
    for (k = 0; k < 60; k++) begin
      @(posedge clk);
      if (k > 0 && chan_busy[ch] === 1'b0) break;
    end
    want[ch] <= 1'b0;
    if (k == 60) begin
      failures++;
      $display("unexpected at %0t: channel hung", $time);
      close_out;
    end
  endtask
  function automatic logic [31:0] cw(input logic [1:0] sz,
    input logic [1:0] sm, input logic [1:0] dm, input logic [1:0] sd);
    return {23'h0, sd, dm, sm, sz, 1'b1};
  endfunction
  // ----
  // Scenarios
  // ----
  initial begin
    clk = 0;
    rst = 1;
    ce = 1;
    reg_we = 0;
    reg_re = 0;
    slow = 0;
    reg_addr = 0;
    reg_wdata = 0;
    want = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Cleared at reset, then own values per channel
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 4; r++) begin
        rd(8'(c * 32 + r * 4), 32'h0);
        wr(8'(c * 32 + r * 4), 32'ha500_0000 + 32'(c * 4 + r));
      end
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 4; r++)
        rd(8'(c * 32 + r * 4), 32'ha500_0000 + 32'(c * 4 + r));
    wr(8'h94, 32'hffff_ffff);
    rd(8'h94, 32'h0);
    rd(8'h14, 32'h0);
    // Byte transfer, offset both sides, end masked then unmasked
    wr(8'h20, 32'h1000);
    wr(8'h24, 32'h2000);
    wr(8'h28, 32'h10);
    wr(8'h2c, 32'h3);
    wr(8'h30, cw(`DMA_CONTROLLER_SZ_BYTE, `DMA_CONTROLLER_AM_OFFSET, `DMA_CONTROLLER_AM_OFFSET, 2'h0));
    go(1);
    rd(8'h20, 32'h1030);
    rd(8'h24, 32'h2030);
    rd(8'h2c, 32'h0);
    irq_is(1'b0);
    wr(8'h84, 32'h2);
    irq_is(1'b1);
    rd(8'h80, 32'h2);
    rd(8'h80, 32'h0);
    irq_is(1'b0);
    // Fixed source, one byte, dual address
    wr(8'h2c, 32'h1);
    wr(8'h30, cw(`DMA_CONTROLLER_SZ_BYTE, `DMA_CONTROLLER_AM_FIXED, `DMA_CONTROLLER_AM_INC, 2'h0));
    go(1);
    rd(8'h20, 32'h1030);
    rd(8'h24, 32'h2031);
    rd(8'h2c, 32'h0);
    rd(8'h80, 32'h2);
    // Word transfer wrapping both ways, then escape
    wr(8'h40, 32'hffff_fffe);
    wr(8'h44, 32'h1);
    wr(8'h4c, 32'h5);
    wr(8'h50, cw(`DMA_CONTROLLER_SZ_WORD, `DMA_CONTROLLER_AM_INC, `DMA_CONTROLLER_AM_DEC, 2'h0));
    go(2);
    rd(8'h40, 32'h2);
    rd(8'h44, 32'hffff_fffd);
    rd(8'h4c, 32'h1);
    rd(8'h80, 32'h40);
    // Longword from the largest count, slow steps, clock held off
    wr(8'h60, 32'h5000);
    wr(8'h64, 32'h7000);
    wr(8'h68, 32'h100);
    wr(8'h6c, 32'hffff_ffff);
    nstep[3] = 0;
    wr(8'h70, cw(2'h2, `DMA_CONTROLLER_AM_OFFSET, `DMA_CONTROLLER_AM_OFFSET, 2'h3));
    want[3] <= 1'b1;
    slow <= 1'b1;
    repeat (6) @(posedge clk);
    ce <= 1'b0;
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    want[3] <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, chan_busy[3]}, 32'h1);
    rd(8'h6c, 32'hffff_ffff - 32'(4 * nstep[3]));
    rd(8'h60, 32'h5000);
    rd(8'h64, 32'h7000 + 32'(256 * nstep[3]));
    wr(8'h70, 32'h0);
    // Free running longwords, destination ignored
    wr(8'h00, 32'h100);
    wr(8'h04, 32'h900);
    wr(8'h0c, 32'h0);
    nstep[0] = 0;
    wr(8'h10, cw(2'h3, `DMA_CONTROLLER_AM_INC, `DMA_CONTROLLER_AM_INC, 2'h1));
    want[0] <= 1'b1;
    slow <= 1'b0;
    repeat (5) @(posedge clk);
    want[0] <= 1'b0;
    repeat (2) @(posedge clk);
    rd(8'h0c, 32'h0);
    rd(8'h04, 32'h900);
    rd(8'h00, 32'h100 + 32'(4 * nstep[0]));
    wr(8'h10, 32'h0);
    close_out;
  end
endmodule // tb_top
